// >>> inc/acdo_cfg.svh
// Constants for the converter output, mode and power control block
`ifndef ACDO_CFG_SVH
`define ACDO_CFG_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define ACDO_W              16
`define ACDO_PAIRS          8
`define ACDO_LATENCY        16
`define ACDO_AW             12
`define ACDO_CTRL_BITS      7
`define ACDO_DRIVE_BITS     12
`define ACDO_STATUS_BITS    6

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define ACDO_OFS_CTRL       12'h000
`define ACDO_OFS_DRIVE      12'h004
`define ACDO_OFS_STATUS     12'h008
`define ACDO_CTRL_RST       7'h00
`define ACDO_DRIVE_RST      12'h000
`define ACDO_LATCH_PHASE    2'h2

// ----------------------------------------
// Output codes
// ----------------------------------------
`define ACDO_OB_POS         16'hFFFF
`define ACDO_OB_NEG         16'h0000
`define ACDO_TC_POS         16'h7FFF
`define ACDO_TC_NEG         16'h8000
`define ACDO_MSB_FLIP       16'h8000

// ----------------------------------------
// Timing, in ns
// ----------------------------------------
`define ACDO_PCLK_NS        40
`define ACDO_SLEEP_WAKE_NS  60000
`define ACDO_STOP_WAKE_NS   80000
`define ACDO_OE_DDR_NS      700
`define ACDO_OE_CMOS_NS     200
`define ACDO_CLKSTOP_NS     1000

`endif

// >>> inc/acdo_pkg.sv
// Types for the converter output, mode and power control block
package acdo_pkg;
`include "acdo_cfg.svh"

	typedef enum logic [1:0]
	{
		PWR_RUN   = 2'b00,
		PWR_SLEEP = 2'b01,
		PWR_STOP  = 2'b10,
		PWR_WAKE  = 2'b11
	} acdo_pwr_t;

	typedef struct packed
	{
		logic [1:0] clock_phase_select;
		logic       twos;
		logic       interface_select_bit;
		logic       noise_shift_enable;
		logic       slow_clock;
		logic       global_sleep_bit;
	} acdo_ctrl_t;

	typedef struct packed
	{
		logic [2:0] clock_pair_termination;
		logic [2:0] data_pair_termination;
		logic       clk_drive_current_boost;
		logic [1:0] clk_drive_current_level;
		logic       data_drive_current_boost;
		logic [1:0] data_drive_current_level;
	} acdo_drive_t;

	typedef struct packed
	{
		logic par_config;
		logic gain_speed;
		logic standby_strap_pin;
		logic oe;
		logic fmt_cmos;
		logic fmt_twos;
		logic latch_strap_pin;
	} acdo_pins_t;

	typedef struct packed
	{
		logic                chop;
		logic                pos;
		logic                neg;
		logic [`ACDO_W-1:0]  word;
	} acdo_smp_t;

	typedef struct packed
	{
		logic        power_down;
		logic        slow_mode;
		logic        noise_shift_enable;
		logic        chop;
		acdo_drive_t drive;
	} acdo_analog_t;

	typedef struct packed
	{
		logic       s1;
		logic       s2;
		logic       s3;
		logic [4:0] cnt;
		logic       stopped;
	} acdo_mon_t;

	typedef struct packed
	{
		acdo_pins_t                        sync1;
		acdo_pins_t                        sync2;
		acdo_ctrl_t                        ctrl;
		acdo_drive_t                       drive;
		acdo_smp_t [`ACDO_LATENCY-1:0]     pipe;
		logic                              chop;
		logic [`ACDO_W-1:0]                word;
		logic                              ovr;
		acdo_pwr_t                         pwr;
		logic [11:0]                       wcnt;
		logic                              oe_prev;
		logic [4:0]                        ocnt;
		logic [3:0]                        ph;
		logic [`ACDO_W-1:0]                pad;
		logic                              pad_oe;
		logic                              fclk;
		logic                              valid;
		logic [31:0]                       rdata;
	} acdo_state_t;

endpackage

// >>> design/acdo_clk_mon.sv
// Sample clock synchroniser, edge finder and stopped-clock watch
`timescale 1ns/100ps
`include "acdo_cfg.svh"
module acdo_clk_mon
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic smp_clk_async,
	output logic      smp_level,
	output logic      smp_rise,
	output logic      clk_stopped
);

	// Least gap that counts as a stopped clock, rounded up
	localparam logic [4:0] STOP_CYC = 5'((`ACDO_CLKSTOP_NS + `ACDO_PCLK_NS - 1) / `ACDO_PCLK_NS);

	acdo_pkg::acdo_mon_t mon_reg;
	acdo_pkg::acdo_mon_t mon_next;

	always_comb
	begin
		mon_next    = mon_reg;
		mon_next.s1 = smp_clk_async;
		mon_next.s2 = mon_reg.s1;
		mon_next.s3 = mon_reg.s2;
		// Full period measured rising to rising, so duty cycle does not matter
		if (mon_reg.s2 && !mon_reg.s3)
			mon_next.cnt = 5'h00;
		else if (mon_reg.cnt != 5'h1F)
			mon_next.cnt = mon_reg.cnt + 5'h01;
		mon_next.stopped = (mon_reg.cnt >= STOP_CYC); // [R6]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mon_reg <= '0;
		else
			mon_reg <= mon_next;
	end

	assign smp_level   = mon_reg.s2;
	assign smp_rise    = mon_reg.s2 && !mon_reg.s3;
	assign clk_stopped = mon_reg.stopped;

endmodule

// >>> design/acdo_ctrl.sv
// Converter output formatting, link drive, mode selection and power control
//
// Overview of operation
// [R1] Noise-shift enable chops the input so low-frequency noise moves to Fs/2.
// [R2] Normal-rate mode after reset in serial config, or gain/speed strap low.
// [R3] Controller picks slow-clock mode below 25 MSPS by bit or strap high.
// [R4] Standby strap or sleep bit powers all down; data valid 60 us after wake.
// [R5] Output enable low tri-states outputs; valid after 700 ns DDR, 200 ns CMOS.
// [R6] Sample clock below 1 MSPS stops the block; valid 80 us after return.
// [R7] Outputs a 16-bit word, forwarded clock and out-of-range flag at full scale.
// [R8] DDR or parallel single-ended interface by format pin or select bit.
// [R9] DDR puts two successive bits on each of eight pairs plus clock pair.
// [R10] DDR: even bits at forwarded clock fall, odd bits at its rise.
// [R11] Receiver captures on both forwarded clock edges to rebuild sixteen bits.
// [R12] Drive current defaults 3.5 mA; 2.5, 4.5, 1.95 mA; optional doubling.
// [R13] Drive level and doubling set separately for data and clock buffers.
// [R14] Three terminations in any combination, separate for data and clock pairs.
// [R15] Single-ended: one pin per bit and clock; data valid at clock rise.
// [R16] Forwarded clock position adjustable by latch strap or phase field.
// [R17] Two's complement or offset binary by format pin or format bit.
// [R18] Positive overdrive gives 0xFFFF offset binary, 0x7FFF two's complement.
// [R19] Negative overdrive gives 0x0000 offset binary, 0x8000 two's complement.
// [R20] Each sample reaches the outputs sixteen sample clocks after it was taken.
// [R21] Out-of-range flag rises and falls with the word it qualifies.
`timescale 1ns/100ps
`include "acdo_cfg.svh"
module acdo_ctrl
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic [`ACDO_AW-1:0]   paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  smp_clk_in,
	input  wire logic [`ACDO_W-1:0]    conv_word,
	input  wire logic                  conv_pos_ovr,
	input  wire logic                  conv_neg_ovr,
	input  wire acdo_pkg::acdo_pins_t  pins_async,
	output logic [`ACDO_W-1:0]         pad_data,
	output logic                       pad_data_oe,
	output logic                       forwarded_clock,
	output logic                       forwarded_clock_oe,
	output logic                       out_of_range,
	output logic                       out_of_range_oe,
	output acdo_pkg::acdo_analog_t     analog
);

	localparam logic [11:0] SLEEP_WAKE_CYC = 12'((`ACDO_SLEEP_WAKE_NS + `ACDO_PCLK_NS - 1) / `ACDO_PCLK_NS);
	localparam logic [11:0] STOP_WAKE_CYC  = 12'((`ACDO_STOP_WAKE_NS + `ACDO_PCLK_NS - 1) / `ACDO_PCLK_NS);
	localparam logic [4:0]  OE_DDR_CYC     = 5'((`ACDO_OE_DDR_NS + `ACDO_PCLK_NS - 1) / `ACDO_PCLK_NS);
	localparam logic [4:0]  OE_CMOS_CYC    = 5'((`ACDO_OE_CMOS_NS + `ACDO_PCLK_NS - 1) / `ACDO_PCLK_NS);

	acdo_pkg::acdo_state_t st_reg;
	acdo_pkg::acdo_state_t st_next;

	logic       smp_level;
	logic       smp_rise;
	logic       clk_stopped;
	logic       eff_sleep;
	logic       eff_cmos;
	logic       eff_twos;
	logic [1:0] eff_phase;
	logic       apb_wr;
	logic       apb_setup;
	logic       addr_ok;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [`ACDO_PAIRS-1:0] ddr_pick(input logic [`ACDO_W-1:0] w, input logic odd);
		logic [`ACDO_PAIRS-1:0] r;
		r = '0;
		for (int i = 0; i < `ACDO_PAIRS; i++)
			r[i] = w[2*i + (odd ? 1 : 0)];
		return r;
	endfunction

	function automatic logic [`ACDO_W-1:0] fmt_word(input acdo_pkg::acdo_smp_t s, input logic twos);
		logic [`ACDO_W-1:0] ob;
		ob = s.chop ? ~s.word : s.word;
		if (s.pos)
			return twos ? `ACDO_TC_POS : `ACDO_OB_POS; // [R18]
		else if (s.neg)
			return twos ? `ACDO_TC_NEG : `ACDO_OB_NEG; // [R19]
		else
			return twos ? (ob ^ `ACDO_MSB_FLIP) : ob; // [R17]
	endfunction

	acdo_clk_mon u_clk_mon
	(
		.pclk          (pclk),
		.presetn       (presetn),
		.smp_clk_async (smp_clk_in),
		.smp_level     (smp_level),
		.smp_rise      (smp_rise),
		.clk_stopped   (clk_stopped)
	);

	// ----------------------------------------
	// Effective mode: straps in parallel config, registers in serial
	// ----------------------------------------
	always_comb
	begin
		if (st_reg.sync2.par_config)
		begin
			eff_sleep = st_reg.sync2.standby_strap_pin; // [R4]
			eff_cmos  = st_reg.sync2.fmt_cmos; // [R8]
			eff_twos  = st_reg.sync2.fmt_twos; // [R17]
			eff_phase = st_reg.sync2.latch_strap_pin ? `ACDO_LATCH_PHASE : 2'h0; // [R16]
		end
		else
		begin
			eff_sleep = st_reg.ctrl.global_sleep_bit; // [R4]
			eff_cmos  = st_reg.ctrl.interface_select_bit; // [R8]
			eff_twos  = st_reg.ctrl.twos; // [R17]
			eff_phase = st_reg.ctrl.clock_phase_select; // [R16]
		end
	end

	assign apb_wr    = psel && penable && pwrite;
	assign apb_setup = psel && !penable;
	assign addr_ok   = (paddr == `ACDO_OFS_CTRL) || (paddr == `ACDO_OFS_DRIVE) || (paddr == `ACDO_OFS_STATUS);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		st_next       = st_reg;
		st_next.sync1 = pins_async;
		st_next.sync2 = st_reg.sync1;

		// Registers
		if (apb_wr && paddr == `ACDO_OFS_CTRL)
			st_next.ctrl = acdo_pkg::acdo_ctrl_t'(pwdata[`ACDO_CTRL_BITS-1:0]);
		if (apb_wr && paddr == `ACDO_OFS_DRIVE)
			st_next.drive = acdo_pkg::acdo_drive_t'(pwdata[`ACDO_DRIVE_BITS-1:0]); // [R12] [R13] [R14]
		// Read data captured in setup so it stands through the access phase
		if (apb_setup)
		begin
			st_next.rdata = 32'h0000_0000;
			unique case (paddr)
				`ACDO_OFS_CTRL:   st_next.rdata[`ACDO_CTRL_BITS-1:0] = st_reg.ctrl;
				`ACDO_OFS_DRIVE:  st_next.rdata[`ACDO_DRIVE_BITS-1:0] = st_reg.drive;
				`ACDO_OFS_STATUS: st_next.rdata[`ACDO_STATUS_BITS-1:0] = {eff_cmos, analog.slow_mode, st_reg.ovr,
					st_reg.pwr == acdo_pkg::PWR_SLEEP, clk_stopped, st_reg.valid};
				default:          st_next.rdata = 32'h0000_0000;
			endcase
		end

		// Pipeline, one stage per sample clock rise
		if (smp_rise)
		begin
			st_next.chop    = st_reg.ctrl.noise_shift_enable ? !st_reg.chop : 1'b0; // [R1]
			st_next.pipe[0] = '{chop: st_reg.chop, pos: conv_pos_ovr, neg: conv_neg_ovr, word: conv_word};
			for (int i = 1; i < `ACDO_LATENCY; i++)
				st_next.pipe[i] = st_reg.pipe[i-1]; // [R20]
			st_next.word = fmt_word(st_reg.pipe[`ACDO_LATENCY-1], eff_twos); // [R7]
			st_next.ovr  = st_reg.pipe[`ACDO_LATENCY-1].pos || st_reg.pipe[`ACDO_LATENCY-1].neg; // [R21]
		end

		// Power state
		unique case (st_reg.pwr)
			acdo_pkg::PWR_RUN:
				if (eff_sleep)
					st_next.pwr = acdo_pkg::PWR_SLEEP;
				else if (clk_stopped)
					st_next.pwr = acdo_pkg::PWR_STOP; // [R6]
			acdo_pkg::PWR_SLEEP:
				if (!eff_sleep)
				begin
					st_next.pwr  = acdo_pkg::PWR_WAKE;
					st_next.wcnt = SLEEP_WAKE_CYC; // [R4]
				end
			acdo_pkg::PWR_STOP:
				if (eff_sleep)
					st_next.pwr = acdo_pkg::PWR_SLEEP;
				else if (!clk_stopped)
				begin
					st_next.pwr  = acdo_pkg::PWR_WAKE;
					st_next.wcnt = STOP_WAKE_CYC; // [R6]
				end
			acdo_pkg::PWR_WAKE:
				if (eff_sleep)
					st_next.pwr = acdo_pkg::PWR_SLEEP;
				else if (clk_stopped)
					st_next.pwr = acdo_pkg::PWR_STOP;
				else if (st_reg.wcnt <= 12'h001)
					st_next.pwr = acdo_pkg::PWR_RUN;
				else
					st_next.wcnt = st_reg.wcnt - 12'h001;
		endcase

		// Output enable recovery time depends on the interface in use
		st_next.oe_prev = st_reg.sync2.oe;
		if (st_reg.sync2.oe && !st_reg.oe_prev)
			st_next.ocnt = eff_cmos ? OE_CMOS_CYC : OE_DDR_CYC; // [R5]
		else if (st_reg.ocnt != 5'h00)
			st_next.ocnt = st_reg.ocnt - 5'h01;

		// Next count, so the cycle that sees the enable rise stays invalid
		st_next.valid = (st_reg.pwr == acdo_pkg::PWR_RUN) && st_reg.sync2.oe && (st_next.ocnt == 5'h00);

		// Pads: ph[0] lines up with the word register
		st_next.ph     = {st_reg.ph[2:0], smp_level};
		st_next.pad_oe = st_reg.sync2.oe && (st_reg.pwr != acdo_pkg::PWR_SLEEP); // [R4] [R5]
		if (!st_reg.valid)
			st_next.pad = '0;
		else if (eff_cmos)
			st_next.pad = st_reg.word; // [R15]
		else
			st_next.pad = {{(`ACDO_W-`ACDO_PAIRS){1'b0}}, ddr_pick(st_reg.word, st_reg.ph[0])}; // [R9] [R10]
		// Single-ended clock is inverted so its rise falls mid-word
		st_next.fclk = eff_cmos ? !st_reg.ph[eff_phase] : st_reg.ph[eff_phase]; // [R15] [R16]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg       <= '0;
			st_reg.ctrl  <= acdo_pkg::acdo_ctrl_t'(`ACDO_CTRL_RST); // [R2]
			st_reg.drive <= acdo_pkg::acdo_drive_t'(`ACDO_DRIVE_RST); // [R12]
			st_reg.pwr   <= acdo_pkg::PWR_RUN;
		end
		else
			st_reg <= st_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata             = st_reg.rdata;
	assign pready             = 1'b1;
	assign pslverr            = psel && penable && (!addr_ok || (pwrite && paddr == `ACDO_OFS_STATUS));
	assign pad_data           = st_reg.pad;
	assign pad_data_oe        = st_reg.pad_oe;
	assign forwarded_clock    = st_reg.fclk;
	assign forwarded_clock_oe = st_reg.pad_oe;
	assign out_of_range       = st_reg.ovr && st_reg.valid;
	assign out_of_range_oe    = st_reg.pad_oe;

	always_comb
	begin
		analog.power_down         = (st_reg.pwr == acdo_pkg::PWR_SLEEP); // [R4]
		// Slow mode requested by the controller below 25 MSPS
		analog.slow_mode          = st_reg.sync2.par_config ? st_reg.sync2.gain_speed : st_reg.ctrl.slow_clock; // [R2] [R3]
		analog.noise_shift_enable = st_reg.ctrl.noise_shift_enable; // [R1]
		analog.chop               = st_reg.chop;
		analog.drive              = st_reg.drive; // [R13] [R14]
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sat_pos_a: assert property ( // [R18]
		(smp_rise && st_reg.pipe[`ACDO_LATENCY-1].pos)
		|=> (st_reg.word == ($past(eff_twos) ? `ACDO_TC_POS : `ACDO_OB_POS)) && st_reg.ovr)
		else $error("positive overdrive code wrong");

	sat_neg_a: assert property ( // [R19]
		(smp_rise && st_reg.pipe[`ACDO_LATENCY-1].neg && !st_reg.pipe[`ACDO_LATENCY-1].pos)
		|=> (st_reg.word == ($past(eff_twos) ? `ACDO_TC_NEG : `ACDO_OB_NEG)) && st_reg.ovr)
		else $error("negative overdrive code wrong");

	ovr_clear_a: assert property ( // [R21]
		(smp_rise && !st_reg.pipe[`ACDO_LATENCY-1].pos && !st_reg.pipe[`ACDO_LATENCY-1].neg) |=> !st_reg.ovr)
		else $error("range flag not cleared with in-range word");

	oe_hiz_a: assert property ( // [R5]
		!st_reg.sync2.oe |=> !pad_data_oe && !forwarded_clock_oe && !out_of_range_oe)
		else $error("outputs driven while disabled");

	oe_wait_a: assert property ( // [R5]
		(st_reg.sync2.oe && !st_reg.oe_prev && !eff_cmos) |=> !st_reg.valid [*8])
		else $error("data valid too soon after output enable");

	sleep_wake_a: assert property ( // [R4]
		(st_reg.pwr == acdo_pkg::PWR_SLEEP && !eff_sleep)
		|=> st_reg.pwr == acdo_pkg::PWR_WAKE && st_reg.wcnt == SLEEP_WAKE_CYC && !analog.power_down)
		else $error("sleep wake count wrong");

	sleep_off_a: assert property ( // [R4]
		(st_reg.pwr == acdo_pkg::PWR_SLEEP) |=> !pad_data_oe && !st_reg.valid)
		else $error("buffers on during sleep");

	stop_enter_a: assert property ( // [R6]
		(st_reg.pwr == acdo_pkg::PWR_RUN && clk_stopped && !eff_sleep) |=> st_reg.pwr == acdo_pkg::PWR_STOP ##1 !st_reg.valid)
		else $error("stopped clock not detected");

	ddr_odd_a: assert property ( // [R10]
		(!eff_cmos && eff_phase == 2'h0 && st_reg.valid && st_reg.ph[0] && !st_reg.ph[1])
		|=> forwarded_clock && pad_data[`ACDO_PAIRS-1:0] == ddr_pick($past(st_reg.word), 1'b1))
		else $error("odd bits not at clock rise");

	ddr_even_a: assert property ( // [R10]
		(!eff_cmos && eff_phase == 2'h0 && st_reg.valid && !st_reg.ph[0] && st_reg.ph[1])
		|=> !forwarded_clock && pad_data[`ACDO_PAIRS-1:0] == ddr_pick($past(st_reg.word), 1'b0))
		else $error("even bits not at clock fall");

	cmos_word_a: assert property ( // [R15]
		(eff_cmos && st_reg.valid) |=> pad_data == $past(st_reg.word))
		else $error("parallel word not on its pins");

	pad_zero_a: assert property ( // [R5]
		!st_reg.valid |=> pad_data == 16'h0000)
		else $error("pads not quiet while data invalid");

	sleep_enter_a: assert property ( // [R4]
		(st_reg.pwr == acdo_pkg::PWR_RUN && eff_sleep) |=> analog.power_down)
		else $error("sleep request not taken");

	wake_run_a: assert property ( // [R4]
		(st_reg.pwr == acdo_pkg::PWR_WAKE && st_reg.wcnt <= 12'h001 && !eff_sleep && !clk_stopped)
		|=> st_reg.pwr == acdo_pkg::PWR_RUN)
		else $error("wake timer did not finish");

	stop_wake_a: assert property ( // [R6]
		(st_reg.pwr == acdo_pkg::PWR_STOP && !clk_stopped && !eff_sleep)
		|=> st_reg.pwr == acdo_pkg::PWR_WAKE && st_reg.wcnt == STOP_WAKE_CYC)
		else $error("stopped clock wake count wrong");

	chop_off_a: assert property ( // [R1]
		(smp_rise && !st_reg.ctrl.noise_shift_enable) |=> !analog.chop)
		else $error("chop running with noise shift off");

	fmt_plain_a: assert property ( // [R17]
		(smp_rise && !st_reg.pipe[`ACDO_LATENCY-1].pos && !st_reg.pipe[`ACDO_LATENCY-1].neg
			&& !st_reg.pipe[`ACDO_LATENCY-1].chop)
		|=> st_reg.word == ($past(st_reg.pipe[`ACDO_LATENCY-1].word) ^ ($past(eff_twos) ? `ACDO_MSB_FLIP : 16'h0000)))
		else $error("output coding wrong");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	wake_cov: cover property (st_reg.pwr == acdo_pkg::PWR_WAKE ##1 st_reg.pwr == acdo_pkg::PWR_RUN);
	stop_cov: cover property (st_reg.pwr == acdo_pkg::PWR_STOP);
	cmos_cov: cover property (eff_cmos && st_reg.valid && forwarded_clock);
	sat_cov:  cover property (out_of_range && pad_data_oe);
	ddr_cov:  cover property (!eff_cmos && st_reg.valid && forwarded_clock);

endmodule

// >>> verification/acdo_rx_model.sv
// Capture receiver model for the double-data-rate output pairs
`timescale 1ns/100ps
module acdo_rx_model
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        fwd_clk,
	input  wire logic [7:0]  pad,
	input  wire logic        oor,
	output logic [16:0]      rx_word,
	output logic             rx_stb
);
	logic       fc_prev;
	logic [7:0] odd_bits;

	// ----------------------------------------
	// Capture on both forwarded clock edges
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fc_prev <= 1'b0;
			odd_bits <= 8'h00;
			rx_stb <= 1'b0;
			rx_word <= 17'h00000;
		end
		else
		begin
			fc_prev <= fwd_clk;
			rx_stb <= fc_prev & !fwd_clk;
			if (!fc_prev && fwd_clk)
				odd_bits <= pad;
			if (fc_prev && !fwd_clk)
			begin
				rx_word[16] <= oor;
				for (int i = 0; i < 8; i++)
					rx_word[2*i +: 2] <= {odd_bits[i], pad[i]};
			end
		end
	end
endmodule

// >>> verification/tb.sv
// Self-checking bench for the converter output and power control block
`timescale 1ns/100ps
`include "acdo_cfg.svh"
module tb;
	logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata, rd, seed, d;
	logic                  er, smp_clk_in, smp_run, conv_pos_ovr, conv_neg_ovr, p, n, c, armed;
	logic [15:0]           conv_word, w, st_word;
	logic                  st_pos, st_neg;
	acdo_pkg::acdo_pins_t  pins;
	logic [15:0]           pad_data;
	logic                  pad_data_oe, forwarded_clock, forwarded_clock_oe, out_of_range, out_of_range_oe;
	acdo_pkg::acdo_analog_t analog;
	logic [16:0]           rx_word;
	logic                  rx_stb;
	logic [2:0]            ph;
	int                    n_stream, rises, cyc, errors, n_checks;
	logic [16:0]           exp_q[$];

	acdo_ctrl i_acdo_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.smp_clk_in(smp_clk_in), .conv_word(conv_word), .conv_pos_ovr(conv_pos_ovr),
		.conv_neg_ovr(conv_neg_ovr), .pins_async(pins), .pad_data(pad_data), .pad_data_oe(pad_data_oe),
		.forwarded_clock(forwarded_clock), .forwarded_clock_oe(forwarded_clock_oe),
		.out_of_range(out_of_range), .out_of_range_oe(out_of_range_oe), .analog(analog));
	acdo_rx_model i_acdo_rx_model (.pclk(pclk), .presetn(presetn), .fwd_clk(forwarded_clock),
		.pad(pad_data[7:0]), .oor(out_of_range), .rx_word(rx_word), .rx_stb(rx_stb));

	always #20 pclk = ~pclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x)
		begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	task automatic give_verdict();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dt);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dt;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic status_valid(input int wait_cyc, input logic x);
		repeat (wait_cyc) @(posedge pclk);
		apb(1'b0, `ACDO_OFS_STATUS, 32'h0);
		chk(32'(rd[0]), 32'(x));
	endtask

	// ----------------------------------------
	// Sample clock, 8 pclk per period, and converter words
	// ----------------------------------------
	always @(posedge pclk)
	begin
		ph <= ph + 3'h1;
		if (ph == 3'h4)
			smp_clk_in <= 1'b0;
		if (ph == 3'h0 && smp_run)
		begin
			smp_clk_in <= 1'b1;
			rises <= (n_stream == 48) ? 0 : rises + 1;
			if (n_stream > 0)
			begin
				seed = lfsr(seed);
				// First word never saturates so the receiver can lock onto it
				p = seed[8:6] == 3'h0 && n_stream != 48;
				n = seed[11:9] == 3'h0 && !p && n_stream != 48;
				w = seed[31:16] | 16'h0001;
				conv_word <= w;
				conv_pos_ovr <= p;
				conv_neg_ovr <= n;
				exp_q.push_back({p | n, p ? 16'hFFFF : n ? 16'h0000 : w});
				n_stream <= n_stream - 1;
			end
			else
			begin
				conv_word <= st_word;
				conv_pos_ovr <= st_pos;
				conv_neg_ovr <= st_neg;
			end
		end
	end

	// ----------------------------------------
	// Result watcher; zero words before the stream carry no note
	// ----------------------------------------
	always @(posedge pclk)
	begin
		if (rx_stb === 1'b1 && (armed || rx_word[15:0] !== 16'h0000) && exp_q.size() > 0)
		begin
			if (!armed)
				chk(32'(rises), 32'h11);
			armed = 1'b1;
			chk(32'(rx_word), 32'(exp_q.pop_front()));
		end
	end

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			give_verdict();
		end
	end

	initial
	begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		smp_clk_in = 0; smp_run = 1; conv_word = 0; conv_pos_ovr = 0; conv_neg_ovr = 0;
		st_word = 0; st_pos = 0; st_neg = 0; ph = 0; armed = 0; seed = 32'hf12fddac;
		n_stream = 0; rises = 0; cyc = 0; errors = 0; n_checks = 0;
		pins = '0;
		pins.oe = 1'b1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (40) @(posedge pclk);
		apb(1'b0, `ACDO_OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, `ACDO_OFS_DRIVE, 32'h0);
		chk(rd, 32'h0);
		d = lfsr(seed) & 32'hFFF;
		apb(1'b1, `ACDO_OFS_DRIVE, d);
		apb(1'b0, `ACDO_OFS_DRIVE, 32'h0);
		chk(rd, d);
		chk(32'(analog.drive), d);
		apb(1'b0, 12'h00C, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		apb(1'b1, `ACDO_OFS_STATUS, 32'hFF);
		chk(32'(er), 32'h1);
		status_valid(0, 1'b1);
		n_stream <= 48;
		repeat (560) @(posedge pclk);
		chk(32'(exp_q.size()), 32'h0);
		pins.oe <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(32'({pad_data_oe, forwarded_clock_oe, out_of_range_oe}), 32'h0);
		pins.oe <= 1'b1;
		status_valid(8, 1'b0);
		status_valid(20, 1'b1);
		apb(1'b1, `ACDO_OFS_CTRL, 32'h1);
		repeat (4) @(posedge pclk);
		chk(32'({analog.power_down, pad_data_oe}), 32'h2);
		apb(1'b1, `ACDO_OFS_CTRL, 32'h0);
		status_valid(1400, 1'b0);
		status_valid(200, 1'b1);
		smp_run <= 1'b0;
		repeat (60) @(posedge pclk);
		apb(1'b0, `ACDO_OFS_STATUS, 32'h0);
		chk(32'(rd[1:0]), 32'h2);
		smp_run <= 1'b1;
		status_valid(1900, 1'b0);
		status_valid(200, 1'b1);
		apb(1'b1, `ACDO_OFS_CTRL, 32'h4);
		repeat (4) @(posedge pclk);
		c = analog.chop;
		repeat (8) @(posedge pclk);
		chk(32'({analog.noise_shift_enable, analog.chop}), 32'({1'b1, !c}));
		apb(1'b1, `ACDO_OFS_CTRL, 32'h2);
		repeat (4) @(posedge pclk);
		chk(32'(analog.slow_mode), 32'h1);
		pins.par_config <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(32'(analog.slow_mode), 32'h0);
		pins.gain_speed <= 1'b1;
		repeat (8) @(posedge pclk);
		chk(32'(analog.slow_mode), 32'h1);
		pins.par_config <= 1'b0;
		st_word <= 16'h1234;
		apb(1'b1, `ACDO_OFS_CTRL, 32'h18);
		for (int k = 0; k < 3; k++)
		begin
			st_pos <= (k == 0);
			st_neg <= (k == 1);
			repeat (200) @(posedge pclk);
			chk(32'({out_of_range, pad_data}), k == 0 ? 32'h17FFF : k == 1 ? 32'h18000 : 32'h09234);
		end
		// Parallel clock rises four cycles after the sample clock falls, phase 0
		@(posedge forwarded_clock);
		@(negedge pclk);
		chk(32'(ph), 32'h1);
		@(posedge pclk);
		pins.par_config <= 1'b1;
		pins.fmt_cmos <= 1'b1;
		pins.latch_strap_pin <= 1'b1;
		repeat (8) @(posedge pclk);
		@(posedge forwarded_clock);
		@(negedge pclk);
		chk(32'(ph), 32'h3);
		give_verdict();
	end
endmodule
